//--- rtl/io_alloc_pkg.sv
// constants for the second-axis input and output signal allocation block
// assumes a 32-bit classic wishbone register bus and one clock domain
package io_alloc_pkg;
	localparam int ADDR_W = 8;
	localparam int NSLOT = 16;
	localparam int NPHYS = 6;
	localparam int NOUT = 3;
	localparam int FN_W = 27;
	localparam int ST_W = 13;
	// register byte offsets
	localparam logic [7:0] OFS_G1_ALLOC_LO = 8'h00;
	localparam logic [7:0] OFS_G1_ALLOC_HI = 8'h04;
	localparam logic [7:0] OFS_G2_ALLOC_LO = 8'h08;
	localparam logic [7:0] OFS_G2_ALLOC_HI = 8'h0c;
	localparam logic [7:0] OFS_G1_INV_LO = 8'h10;
	localparam logic [7:0] OFS_G1_INV_HI = 8'h14;
	localparam logic [7:0] OFS_G2_INV_LO = 8'h18;
	localparam logic [7:0] OFS_G2_INV_HI = 8'h1c;
	localparam logic [7:0] OFS_BUS_EN_A = 8'h20;
	localparam logic [7:0] OFS_BUS_EN_B = 8'h24;
	localparam logic [7:0] OFS_OUT_ALLOC = 8'h28;
	localparam logic [7:0] OFS_OUT_INV = 8'h2c;
	localparam logic [7:0] OFS_VIRT_IN = 8'h30;
	localparam logic [7:0] OFS_LEVELS = 8'h34;
	localparam logic [7:0] OFS_FUNCS = 8'h38;
	// input function codes
	localparam logic [7:0] CODE_SERVO_ENABLE = 8'h40;
	localparam logic [7:0] CODE_PROP_LOOP = 8'h41;
	localparam logic [7:0] CODE_PLAIN_FIRST = 8'h02;
	localparam logic [7:0] CODE_PLAIN_LAST = 8'h1a;
	localparam logic [7:0] CODE_NONE = 8'hff;
	// function vector bit positions; plain codes sit at their own value
	localparam int FN_SERVO_ENABLE = 0;
	localparam int FN_PROP_LOOP = 1;
	localparam int FN_FWD_INHIBIT = 2;
	localparam int FN_REV_INHIBIT = 3;
	localparam int FN_FAULT_CLEAR = 4;
	localparam int FN_DEV_CLEAR = 5;
	localparam int FN_FWD_CLAMP = 6;
	localparam int FN_REV_CLAMP = 7;
	localparam int FN_GAIN_SELECT = 8;
	localparam int FN_JOG_PLUS = 9;
	localparam int FN_JOG_MINUS = 10;
	localparam int FN_JOG_HALT = 11;
	localparam int FN_HOMING_INPUT = 12;
	localparam int FN_HOMING_START = 13;
	localparam int FN_REF_SWITCH = 14;
	localparam int FN_ZERO_HOLD = 15;
	localparam int FN_TQ_CONTACT_1 = 16;
	localparam int FN_TQ_CONTACT_2 = 17;
	localparam int FN_TQ_LIMIT_1 = 18;
	localparam int FN_TQ_LIMIT_2 = 19;
	localparam int FN_ANALOG_NEGATE = 20;
	localparam int FN_POINT_SEL_0 = 21;
	localparam int FN_GAIN_SWITCH = 26;
	// output status codes
	localparam logic [3:0] ST_POS_DONE = 4'h0;
	localparam logic [3:0] ST_ROTATING = 4'h1;
	localparam logic [3:0] ST_SERVO_READY = 4'h2;
	localparam logic [3:0] ST_TORQUE_LIMIT = 4'h3;
	localparam logic [3:0] ST_BRAKE = 4'h4;
	localparam logic [3:0] ST_NONE = 4'hf;
	// reset values
	localparam logic [15:0][7:0] CODE_RST = {{10{8'hff}},
		8'h05, 8'h04, 8'h03, 8'h02, 8'h41, 8'h40};
	localparam logic [15:0] INV_RST = 16'h0000;
	localparam logic [5:0] BUS_EN_RST = 6'h00;
	localparam logic [15:0] VIRT_RST = 16'h0000;
	localparam logic [23:0] OUT_ALLOC_RST = 24'hf2f1f0;
	localparam logic [2:0] OUT_INV_RST = 3'h0;
endpackage

//--- rtl/axis_io_signal_allocation.sv
// second-axis input slot selection, inversion, function decode and output groups
// assumes a classic wishbone master and inputs synchronous to mclk except phys_in
`timescale 1ns/1ps
module axis_io_signal_allocation
(
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [io_alloc_pkg::ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [io_alloc_pkg::NPHYS-1:0] phys_in,
	input wire logic mode_analog_speed,
	input wire logic mode_analog_torque,
	input wire logic [io_alloc_pkg::ST_W-1:0] status_func,
	output logic [io_alloc_pkg::NOUT-1:0] out_group,
	output logic servo_enable_request,
	output logic proportional_loop_request,
	output logic forward_travel_inhibit,
	output logic reverse_travel_inhibit,
	output logic fault_clear,
	output logic deviation_clear,
	output logic forward_torque_clamp,
	output logic reverse_torque_clamp,
	output logic gain_select,
	output logic jog_plus,
	output logic jog_minus,
	output logic jog_halt,
	output logic homing_input,
	output logic homing_start,
	output logic reference_switch,
	output logic zero_speed_hold,
	output logic internal_torque_contact_1,
	output logic internal_torque_contact_2,
	output logic internal_torque_limit_1,
	output logic internal_torque_limit_2,
	output logic analog_command_negate,
	output logic point_table_sel_0,
	output logic point_table_sel_1,
	output logic point_table_sel_2,
	output logic point_table_sel_3,
	output logic point_table_sel_4,
	output logic analog_gain_switch,
	output logic alt_speed_gain,
	output logic alt_torque_gain
);
	import io_alloc_pkg::*;

	typedef struct packed {
		logic [NPHYS-1:0] sync1;
		logic [NPHYS-1:0] sync2;
		logic [NSLOT-1:0][7:0] code;
		logic [NSLOT-1:0] inv;
		logic [NPHYS-1:0] bus_en;
		logic [NSLOT-1:0] virt;
		logic [NOUT-1:0][7:0] ocode;
		logic [NOUT-1:0] oinv;
		logic [NSLOT-1:0] slot;
		logic [FN_W-1:0] fn;
		logic alt_spd;
		logic alt_trq;
		logic [NOUT-1:0] opin;
		logic ack;
		logic [31:0] rdat;
	} st_s;

	st_s st_ff;
	st_s nxt_st;
	logic [31:0] wr_word;
	logic [4:0] fn_pos;
	logic bus_req;

	// map a slot code to its function bit, 31 when unassigned
	function automatic logic [4:0] fn_index(input logic [7:0] c);
		if (c == CODE_SERVO_ENABLE)
			return 5'(FN_SERVO_ENABLE);
		if (c == CODE_PROP_LOOP)
			return 5'(FN_PROP_LOOP);
		if (c >= CODE_PLAIN_FIRST && c <= CODE_PLAIN_LAST)
			return c[4:0];
		return 5'h1f;
	endfunction

	// level of the status function chosen by a 4-bit output code
	function automatic logic st_hit(input logic [3:0] c, input logic [ST_W-1:0] s);
		if (c < 4'(ST_W))
			return s[c];
		return 1'b0;
	endfunction

	// merge a write into the current word under byte selects
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++)
		begin
			if (s[b])
				r[8*b +: 8] = n[8*b +: 8];
		end
		return r;
	endfunction

	// register read mux; unmapped offsets read zero
	function automatic logic [31:0] reg_read(input st_s q, input logic [ADDR_W-1:0] a);
		logic [31:0] r;
		r = 32'h0;
		case (a)
			OFS_G1_ALLOC_LO: r = q.code[3:0];
			OFS_G1_ALLOC_HI: r = q.code[7:4];
			OFS_G2_ALLOC_LO: r = q.code[11:8];
			OFS_G2_ALLOC_HI: r = q.code[15:12];
			OFS_G1_INV_LO: r[3:0] = q.inv[3:0];
			OFS_G1_INV_HI: r[3:0] = q.inv[7:4];
			OFS_G2_INV_LO: r[3:0] = q.inv[11:8];
			OFS_G2_INV_HI: r[3:0] = q.inv[15:12];
			OFS_BUS_EN_A: r[3:0] = q.bus_en[3:0];
			OFS_BUS_EN_B: r[1:0] = q.bus_en[5:4];
			OFS_OUT_ALLOC: r[23:0] = q.ocode;
			OFS_OUT_INV: r[2:0] = q.oinv;
			OFS_VIRT_IN: r[15:0] = q.virt;
			OFS_LEVELS: r[18:0] = {q.opin, q.slot};
			OFS_FUNCS: r[FN_W-1:0] = q.fn;
			default: r = 32'h0;
		endcase
		return r;
	endfunction

	// whether any slot holds the given code
	function automatic logic code_used(input logic [NSLOT-1:0][7:0] q, input logic [7:0] c);
		logic r;
		r = 1'b0;
		for (int s = 0; s < NSLOT; s++)
		begin
			if (q[s] == c)
				r = 1'b1;
		end
		return r;
	endfunction

	always_comb
	begin
		nxt_st = st_ff;
		fn_pos = 5'h1f;
		// two-stage synchroniser on the connector inputs
		nxt_st.sync1 = phys_in;
		nxt_st.sync2 = st_ff.sync1;
		// slot source select and inversion
		for (int i = 0; i < NSLOT; i++)
		begin
			if (i < NPHYS && !st_ff.bus_en[i])
				nxt_st.slot[i] = st_ff.sync2[i] ^ st_ff.inv[i];
			else
				nxt_st.slot[i] = st_ff.virt[i] ^ st_ff.inv[i];
		end
		// function decode; lowest slot wins when a code repeats
		nxt_st.fn = '0;
		for (int s = NSLOT - 1; s >= 0; s--)
		begin
			fn_pos = fn_index(st_ff.code[s]);
			if (fn_pos < 5'(FN_W))
				nxt_st.fn[fn_pos] = st_ff.slot[s];
		end
		// alternate analog gains
		nxt_st.alt_spd = st_ff.fn[FN_GAIN_SWITCH] & mode_analog_speed;
		nxt_st.alt_trq = st_ff.fn[FN_GAIN_SWITCH] & mode_analog_torque;
		// output groups, two codes each, ORed then optionally inverted
		for (int g = 0; g < NOUT; g++)
		begin
			nxt_st.opin[g] = (st_hit(st_ff.ocode[g][3:0], status_func)
				| st_hit(st_ff.ocode[g][7:4], status_func))
				^ st_ff.oinv[g];
		end
		// wishbone classic slave, one wait state
		bus_req = wb_cyc_i & wb_stb_i;
		nxt_st.ack = bus_req & ~st_ff.ack;
		if (bus_req && !st_ff.ack)
			nxt_st.rdat = reg_read(st_ff, wb_adr_i);
		wr_word = merge(reg_read(st_ff, wb_adr_i), wb_dat_i, wb_sel_i);
		if (bus_req && st_ff.ack && wb_we_i)
		begin
			case (wb_adr_i)
				OFS_G1_ALLOC_LO: nxt_st.code[3:0] = wr_word;
				OFS_G1_ALLOC_HI: nxt_st.code[7:4] = wr_word;
				OFS_G2_ALLOC_LO: nxt_st.code[11:8] = wr_word;
				OFS_G2_ALLOC_HI: nxt_st.code[15:12] = wr_word;
				OFS_G1_INV_LO: nxt_st.inv[3:0] = wr_word[3:0];
				OFS_G1_INV_HI: nxt_st.inv[7:4] = wr_word[3:0];
				OFS_G2_INV_LO: nxt_st.inv[11:8] = wr_word[3:0];
				OFS_G2_INV_HI: nxt_st.inv[15:12] = wr_word[3:0];
				OFS_BUS_EN_A: nxt_st.bus_en[3:0] = wr_word[3:0];
				OFS_BUS_EN_B: nxt_st.bus_en[5:4] = wr_word[1:0];
				OFS_OUT_ALLOC: nxt_st.ocode = wr_word[23:0];
				OFS_OUT_INV: nxt_st.oinv = wr_word[2:0];
				OFS_VIRT_IN: nxt_st.virt = wr_word[15:0];
				default: nxt_st.virt = st_ff.virt;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st_ff <= '0;
			st_ff.code <= CODE_RST;
			st_ff.inv <= INV_RST;
			st_ff.bus_en <= BUS_EN_RST;
			st_ff.virt <= VIRT_RST;
			st_ff.ocode <= OUT_ALLOC_RST;
			st_ff.oinv <= OUT_INV_RST;
		end
		else
			st_ff <= nxt_st;
	end

	assign wb_ack_o = st_ff.ack;
	assign wb_dat_o = st_ff.rdat;
	assign out_group = st_ff.opin;
	assign servo_enable_request = st_ff.fn[FN_SERVO_ENABLE];
	assign proportional_loop_request = st_ff.fn[FN_PROP_LOOP];
	assign forward_travel_inhibit = st_ff.fn[FN_FWD_INHIBIT];
	assign reverse_travel_inhibit = st_ff.fn[FN_REV_INHIBIT];
	assign fault_clear = st_ff.fn[FN_FAULT_CLEAR];
	assign deviation_clear = st_ff.fn[FN_DEV_CLEAR];
	assign forward_torque_clamp = st_ff.fn[FN_FWD_CLAMP];
	assign reverse_torque_clamp = st_ff.fn[FN_REV_CLAMP];
	assign gain_select = st_ff.fn[FN_GAIN_SELECT];
	assign jog_plus = st_ff.fn[FN_JOG_PLUS];
	assign jog_minus = st_ff.fn[FN_JOG_MINUS];
	assign jog_halt = st_ff.fn[FN_JOG_HALT];
	assign homing_input = st_ff.fn[FN_HOMING_INPUT];
	assign homing_start = st_ff.fn[FN_HOMING_START];
	assign reference_switch = st_ff.fn[FN_REF_SWITCH];
	assign zero_speed_hold = st_ff.fn[FN_ZERO_HOLD];
	assign internal_torque_contact_1 = st_ff.fn[FN_TQ_CONTACT_1];
	assign internal_torque_contact_2 = st_ff.fn[FN_TQ_CONTACT_2];
	assign internal_torque_limit_1 = st_ff.fn[FN_TQ_LIMIT_1];
	assign internal_torque_limit_2 = st_ff.fn[FN_TQ_LIMIT_2];
	assign analog_command_negate = st_ff.fn[FN_ANALOG_NEGATE];
	assign point_table_sel_0 = st_ff.fn[FN_POINT_SEL_0];
	assign point_table_sel_1 = st_ff.fn[FN_POINT_SEL_0 + 1];
	assign point_table_sel_2 = st_ff.fn[FN_POINT_SEL_0 + 2];
	assign point_table_sel_3 = st_ff.fn[FN_POINT_SEL_0 + 3];
	assign point_table_sel_4 = st_ff.fn[FN_POINT_SEL_0 + 4];
	assign analog_gain_switch = st_ff.fn[FN_GAIN_SWITCH];
	assign alt_speed_gain = st_ff.alt_spd;
	assign alt_torque_gain = st_ff.alt_trq;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!arst_n);

	bus_ack_once_a: assert property (bus_req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a single pulse one cycle after request");
	port_sync_path_a: assert property (
		(!st_ff.bus_en[0] && !st_ff.inv[0])[*3] |-> st_ff.slot[0] == $past(phys_in[0], 3))
		else $error("physical slot level not three cycles behind the pin");
	bus_ctrl_swap_a: assert property ($past(st_ff.bus_en[1]) |->
		st_ff.slot[1] == ($past(st_ff.virt[1]) ^ $past(st_ff.inv[1])))
		else $error("bus controlled slot does not follow virtual bit");
	virtual_only_a: assert property ($past(arst_n) |->
		st_ff.slot[7] == ($past(st_ff.virt[7]) ^ $past(st_ff.inv[7])))
		else $error("slot seven not driven by virtual bit seven");
	group_two_a: assert property ($past(arst_n) |->
		st_ff.slot[8] == ($past(st_ff.virt[8]) ^ $past(st_ff.inv[8])))
		else $error("slot eight not driven by virtual bit eight");
	servo_decode_a: assert property ($past(st_ff.code[0]) == CODE_SERVO_ENABLE |->
		servo_enable_request == $past(st_ff.slot[0]))
		else $error("servo enable does not follow its slot");
	plain_decode_a: assert property ($past(st_ff.code[0]) == 8'h02 |->
		forward_travel_inhibit == $past(st_ff.slot[0]))
		else $error("forward inhibit does not follow its slot");
	torque_decode_a: assert property ($past(st_ff.code[2]) == 8'h10 &&
		$past(st_ff.code[1]) != 8'h10 && $past(st_ff.code[0]) != 8'h10 |->
		internal_torque_contact_1 == $past(st_ff.slot[2]))
		else $error("torque contact one does not follow its slot");
	gain_switch_a: assert property ($past(st_ff.fn[FN_GAIN_SWITCH]) &&
		$past(mode_analog_speed) |-> alt_speed_gain)
		else $error("alternate speed gain not selected");
	out_or_a: assert property ($past(st_ff.ocode[0]) == 8'h43 &&
		!$past(st_ff.oinv[0]) |-> out_group[0] == $past(status_func[3] | status_func[4]))
		else $error("shared output group is not the OR");
	out_invert_a: assert property ($past(st_ff.ocode[0]) == 8'hf4 &&
		$past(st_ff.oinv[0]) |-> out_group[0] == !$past(status_func[4]))
		else $error("inverted brake output wrong");
	bus_en_write_a: assert property (bus_req && wb_ack_o && wb_we_i &&
		wb_sel_i[0] && wb_adr_i == OFS_BUS_EN_B |=> st_ff.bus_en[5:4] == $past(wb_dat_i[1:0]))
		else $error("bus control enable write lost");
	ack_needs_req_a: assert property (!bus_req |=> !wb_ack_o)
		else $error("ack without a request");
	read_virt_a: assert property (bus_req && !wb_ack_o && !wb_we_i &&
		wb_adr_i == OFS_VIRT_IN |=> wb_dat_o == {16'h0, $past(st_ff.virt)})
		else $error("virtual input word read back wrong");
	phys_invert_a: assert property (!$past(st_ff.bus_en[1]) |->
		st_ff.slot[1] == ($past(st_ff.sync2[1]) ^ $past(st_ff.inv[1])))
		else $error("physical slot inversion wrong");
	slot_six_a: assert property ($past(arst_n) |->
		st_ff.slot[6] == ($past(st_ff.virt[6]) ^ $past(st_ff.inv[6])))
		else $error("slot six not driven by virtual bit six");
	group_two_end_a: assert property ($past(arst_n) |->
		st_ff.slot[15] == ($past(st_ff.virt[15]) ^ $past(st_ff.inv[15])))
		else $error("slot fifteen not driven by virtual bit fifteen");
	prop_decode_a: assert property ($past(st_ff.code[1]) == CODE_PROP_LOOP &&
		$past(st_ff.code[0]) != CODE_PROP_LOOP |->
		proportional_loop_request == $past(st_ff.slot[1]))
		else $error("proportional request does not follow its slot");
	negate_owner_a: assert property (analog_command_negate |->
		$past(code_used(st_ff.code, 8'h14)))
		else $error("analog negate set with no slot holding its code");
	point_owner_a: assert property (point_table_sel_4 |->
		$past(code_used(st_ff.code, 8'h19)))
		else $error("point select four set with no slot holding its code");
	limit_owner_a: assert property (internal_torque_limit_2 |->
		$past(code_used(st_ff.code, 8'h13)))
		else $error("torque limit two set with no slot holding its code");
	brake_decode_a: assert property ($past(st_ff.ocode[0]) == 8'hf4 &&
		!$past(st_ff.oinv[0]) |-> out_group[0] == $past(status_func[4]))
		else $error("brake code output wrong");
	torque_gain_a: assert property ($past(st_ff.fn[FN_GAIN_SWITCH]) &&
		$past(mode_analog_torque) |-> alt_torque_gain)
		else $error("alternate torque gain not selected");
	gain_idle_a: assert property (!$past(st_ff.fn[FN_GAIN_SWITCH]) |->
		!alt_speed_gain && !alt_torque_gain)
		else $error("alternate gain without the gain switch");
	bus_en_low_a: assert property (bus_req && wb_ack_o && wb_we_i &&
		wb_sel_i[0] && wb_adr_i == OFS_BUS_EN_A |=> st_ff.bus_en[3:0] == $past(wb_dat_i[3:0]))
		else $error("low bus control enable write lost");
endmodule

//--- bench/host_io_model.sv
// host controller side: connector input wiring and drive status levels
// assumes the bench sets requests just after a rising mclk edge
`timescale 1ns/1ps
module host_io_model
(
	input wire logic mclk,
	input wire logic [io_alloc_pkg::NPHYS-1:0] pin_req,
	input wire logic [io_alloc_pkg::ST_W-1:0] stat_req,
	output logic [io_alloc_pkg::NPHYS-1:0] phys_in,
	output logic [io_alloc_pkg::ST_W-1:0] status_func
);
	import io_alloc_pkg::*;
	initial
	begin
		phys_in = '0;
		status_func = '0;
	end
	// a driver stage on the wiring: levels follow one edge late
	always @(posedge mclk)
	begin
		phys_in <= pin_req;
		status_func <= stat_req;
	end
endmodule

//--- bench/axis_io_signal_allocation_tb.sv
// bench for the second-axis signal allocation block
// assumes a classic wishbone master here and the host model on the pins
`timescale 1ns/1ps
module axis_io_signal_allocation_tb;
	import io_alloc_pkg::*;
	logic mclk, arst_n, cyc, stb, we, ack, m_spd, m_trq, a_spd, a_trq;
	logic [ADDR_W-1:0] adr;
	logic [3:0] sel;
	logic [31:0] dw, dr, rd;
	logic [NPHYS-1:0] pin_req, phys_in;
	logic [ST_W-1:0] stat_req, status_func;
	logic [NOUT-1:0] og;
	logic [FN_W-1:0] fn;
	int num_errors, n_tests, cycles;
	host_io_model host (.mclk(mclk), .pin_req(pin_req), .stat_req(stat_req),
		.phys_in(phys_in), .status_func(status_func));
	axis_io_signal_allocation DUT (.mclk(mclk), .arst_n(arst_n), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw),
		.wb_dat_o(dr), .wb_ack_o(ack), .phys_in(phys_in), .mode_analog_speed(m_spd),
		.mode_analog_torque(m_trq), .status_func(status_func), .out_group(og),
		.servo_enable_request(fn[0]), .proportional_loop_request(fn[1]),
		.forward_travel_inhibit(fn[2]), .reverse_travel_inhibit(fn[3]), .fault_clear(fn[4]),
		.deviation_clear(fn[5]), .forward_torque_clamp(fn[6]), .reverse_torque_clamp(fn[7]),
		.gain_select(fn[8]), .jog_plus(fn[9]), .jog_minus(fn[10]), .jog_halt(fn[11]),
		.homing_input(fn[12]), .homing_start(fn[13]), .reference_switch(fn[14]),
		.zero_speed_hold(fn[15]), .internal_torque_contact_1(fn[16]),
		.internal_torque_contact_2(fn[17]), .internal_torque_limit_1(fn[18]),
		.internal_torque_limit_2(fn[19]), .analog_command_negate(fn[20]),
		.point_table_sel_0(fn[21]), .point_table_sel_1(fn[22]), .point_table_sel_2(fn[23]),
		.point_table_sel_3(fn[24]), .point_table_sel_4(fn[25]), .analog_gain_switch(fn[26]),
		.alt_speed_gain(a_spd), .alt_torque_gain(a_trq));
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp)
		begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one classic cycle; request held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hf;
		dw <= d;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (ack !== 1'b1 && n < 50);
		rd = dr;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (n >= 50)
			chk("ack", 32'h1, 32'h0);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
		wb(1'b0, a, 32'h0);
		chk(what, exp, rd);
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic t_reset();
		rdchk(OFS_G1_ALLOC_LO, 32'h03024140, "slot codes 0-3");
		rdchk(OFS_G1_ALLOC_HI, 32'hffff0504, "slot codes 4-7");
		rdchk(OFS_OUT_ALLOC, 32'h00f2f1f0, "output alloc");
		wb(1'b1, 8'h3c, 32'hffffffff);
		rdchk(8'h3c, 32'h0, "unmapped");
	endtask
	task automatic t_phys();
		pin_req <= 6'h3f;
		settle(4);
		chk("fn early", 32'h0, {5'h0, fn});
		settle(2);
		chk("fn from pins", 32'h3f, {5'h0, fn});
	endtask
	task automatic t_bus_en();
		wb(1'b1, OFS_BUS_EN_A, 32'h1);
		wb(1'b1, OFS_BUS_EN_B, 32'hfe);
		rdchk(OFS_BUS_EN_B, 32'h2, "bus enable b");
		settle(4);
		chk("bus ctrl off virt", 32'h1e, {5'h0, fn});
		wb(1'b1, OFS_VIRT_IN, 32'h21);
		rdchk(OFS_VIRT_IN, 32'h21, "virtual word");
		settle(4);
		chk("bus ctrl on virt", 32'h3f, {5'h0, fn});
		wb(1'b1, OFS_BUS_EN_A, 32'h0);
		wb(1'b1, OFS_BUS_EN_B, 32'h0);
		wb(1'b1, OFS_G1_INV_LO, 32'h2);
		settle(4);
		chk("inverted slot", 32'h3d, {5'h0, fn});
		wb(1'b1, OFS_G1_INV_LO, 32'h0);
	endtask
	task automatic t_codes();
		logic [7:0] c;
		int b;
		pin_req <= 6'h0;
		wb(1'b1, OFS_G1_ALLOC_LO, 32'hffffffff);
		wb(1'b1, OFS_G1_ALLOC_HI, 32'hffffffff);
		wb(1'b1, OFS_VIRT_IN, 32'h100);
		for (int i = 0; i < 27; i++)
		begin
			c = (i < 25) ? 8'(i + 2) : ((i == 25) ? CODE_SERVO_ENABLE : CODE_PROP_LOOP);
			b = (i < 25) ? i + 2 : i - 25;
			wb(1'b1, OFS_G2_ALLOC_LO, {24'hffffff, c});
			settle(4);
			chk("decoded fn", 32'h1 << b, {5'h0, fn});
		end
		wb(1'b1, OFS_G2_ALLOC_LO, 32'hffffffff);
		wb(1'b1, OFS_G2_ALLOC_HI, 32'h14ffffff);
		wb(1'b1, OFS_G1_ALLOC_HI, 32'h15ffffff);
		wb(1'b1, OFS_G2_INV_HI, 32'h8);
		wb(1'b1, OFS_VIRT_IN, 32'h80);
		settle(4);
		chk("slots 7 and 15", 32'h300000, {5'h0, fn});
		rdchk(OFS_FUNCS, 32'h300000, "function word");
	endtask
	task automatic t_gain();
		wb(1'b1, OFS_G2_INV_HI, 32'h0);
		wb(1'b1, OFS_G2_ALLOC_HI, 32'hffffff1a);
		wb(1'b1, OFS_VIRT_IN, 32'h1000);
		m_spd <= 1'b1;
		settle(4);
		chk("alt gains speed", 32'h2, {30'h0, a_spd, a_trq});
		m_spd <= 1'b0;
		m_trq <= 1'b1;
		settle(3);
		chk("alt gains torque", 32'h1, {30'h0, a_spd, a_trq});
	endtask
	task automatic t_out();
		for (int k = 0; k < 5; k++)
		begin
			wb(1'b1, OFS_OUT_ALLOC, {16'hffff, 4'hf, 4'(k)});
			stat_req <= 13'h1 << k;
			settle(4);
			chk("group on", 32'h1, {29'h0, og});
			stat_req <= ~(13'h1 << k);
			settle(4);
			chk("group off", 32'h0, {29'h0, og});
		end
		wb(1'b1, OFS_OUT_ALLOC, 32'h00ffff43);
		stat_req <= 13'h10;
		settle(4);
		chk("or code b", 32'h1, {29'h0, og});
		stat_req <= 13'h8;
		settle(4);
		chk("or code a", 32'h1, {29'h0, og});
		stat_req <= 13'h0;
		wb(1'b1, OFS_OUT_INV, 32'h5);
		settle(4);
		chk("inverted groups", 32'h5, {29'h0, og});
		wb(1'b1, OFS_OUT_ALLOC, 32'h00fffff4);
		stat_req <= 13'h10;
		settle(4);
		chk("inverted brake", 32'h4, {29'h0, og});
	endtask
	initial
	begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			num_errors++;
			end_of_test();
		end
	end
	initial
	begin
		{arst_n, cyc, stb, we, m_spd, m_trq} = 6'h0;
		adr = '0;
		dw = '0;
		sel = '0;
		pin_req = '0;
		stat_req = '0;
		num_errors = 0;
		n_tests = 0;
		cycles = 0;
		settle(4);
		arst_n <= 1'b1;
		t_reset();
		t_phys();
		t_bus_en();
		t_codes();
		t_gain();
		t_out();
		end_of_test();
	end
endmodule
